/* src/timer_pwm_unit.sv */
// Sixteen-bit timer with prescaler, coherent counter reads and one capture, compare or PWM channel.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - The clock source field stops the counter at 00 and picks bus, fixed or external clock at 01, 10, 11.
// - The external clock is synchronised to the bus clock inside the unit before it advances the prescaler.
// - Without an enabled frequency or phase locked loop, the fixed clock choice behaves as the bus clock.
// - The prescale field divides the selected clock by two to the power of its value, 1 up to 128.
// - The prescaler follows source selection and synchronisation and divides whichever source is chosen.
// - A new prescale value acts from the clock cycle after the register bits change.
// - The counter is read as a high byte and a low byte through two read-only registers.
// - Reading either byte latches both, and reads return the latched value until the other byte is read.
// - The read latch returns to idle on reset and on any write to the status and control register.
// - In center-aligned mode the overflow flag is set when the counter turns from up to down at the modulo.
// - An input capture channel sets its flag on the edge its two edge-select bits choose.
// - An output compare channel sets its flag each time the counter equals its value register.
// - An edge-aligned PWM channel sets its flag when the counter equals its value, ending the duty cycle.
// - A center-aligned PWM channel sets its flag at both matches of the counter with its value.
module timer_pwm_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic ext_clk_pin,
  input wire logic fixed_clk_tick,
  input wire logic pll_present,
  input wire logic pll_enable,
  input wire logic chan_pin,
  output logic chan_out,
  output logic counter_overflow_flag,
  output logic channel_flag
);

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] sc_ff;
  logic [3:0] ch_ff;
  logic [15:0] cnt_ff;
  logic [15:0] mod_ff;
  logic [15:0] chval_ff;
  logic [15:0] buf_ff;
  logic [6:0] presc_ff;
  logic up_ff;
  logic tof_ff;
  logic tof_arm_ff;
  logic chf_ff;
  logic chf_arm_ff;
  logic chan_out_ff;
  logic [7:0] rd_data_ff;
  timer_pkg::latch_e latch_ff;

  logic ext_rise;
  logic chan_level;
  logic chan_rise;
  logic chan_fall;
  timer_pkg::clk_src_e clk_src;
  timer_pkg::edge_sel_e edge_sel;
  timer_pkg::chan_mode_e chan_mode;
  logic center_mode;
  logic [2:0] ps;
  logic [6:0] ps_mask;
  logic src_tick;
  logic count_tick;
  logic [15:0] top;
  logic [15:0] nxt_cnt;
  logic nxt_up;
  logic reverse_top;
  logic wrap;
  logic chan_match;
  logic capture_hit;
  logic sc_write;
  logic ch_write;
  logic [7:0] nxt_rd_data;

  function automatic logic edge_hit(input timer_pkg::edge_sel_e sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    case (sel)
      timer_pkg::EDGE_RISE: hit = r;
      timer_pkg::EDGE_FALL: hit = f;
      timer_pkg::EDGE_BOTH: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  ////////////////////////////////////////////////////////////////////////////
  pin_sync sync_ext (
    .clk(clk),
    .resetn(resetn),
    .pin(ext_clk_pin),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  pin_sync sync_chan (
    .clk(clk),
    .resetn(resetn),
    .pin(chan_pin),
    .level(chan_level),
    .rise(chan_rise),
    .fall(chan_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign clk_src = timer_pkg::clk_src_e'(sc_ff[timer_pkg::SC_CLKS_LSB +: 2]);
  assign ps = sc_ff[timer_pkg::SC_PS_LSB +: 3];
  assign center_mode = sc_ff[timer_pkg::SC_CENTER_BIT];
  assign edge_sel = timer_pkg::edge_sel_e'(ch_ff[timer_pkg::CH_EDGE_LSB - 2 +: 2]);
  assign chan_mode = timer_pkg::chan_mode_e'(ch_ff[timer_pkg::CH_MODE_LSB - 2 +: 2]);
  assign sc_write = wr_en && (addr == timer_pkg::OFF_STATUS_CONTROL);
  assign ch_write = wr_en && (addr == timer_pkg::OFF_CHANNEL_CONTROL);
  assign top = (mod_ff == 16'h0000) ? timer_pkg::FREE_RUN_TOP : mod_ff;

  always_comb begin
    case (clk_src)
      timer_pkg::CLK_OFF: src_tick = 1'b0;
      timer_pkg::CLK_BUS: src_tick = 1'b1;
      timer_pkg::CLK_FIXED: src_tick = (pll_present && pll_enable) ? fixed_clk_tick : 1'b1;
      default: src_tick = ext_rise;
    endcase
  end

  // The mask is taken from the live register bits, so a new factor acts on the very next cycle.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      ps_mask[i] = (i < int'(ps));
    end
  end

  assign count_tick = src_tick && ((presc_ff | ~ps_mask) == 7'h7f);

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    reverse_top = 1'b0;
    wrap = 1'b0;
    if (count_tick) begin
      if (center_mode) begin
        if (up_ff) begin
          if (cnt_ff >= top) begin
            nxt_cnt = cnt_ff - 16'h0001;
            nxt_up = 1'b0;
            reverse_top = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end else begin
          if (cnt_ff == 16'h0000) begin
            nxt_cnt = 16'h0001;
            nxt_up = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end else begin
        nxt_up = 1'b1;
        if (cnt_ff >= top) begin
          nxt_cnt = 16'h0000;
          wrap = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
    end
  end

  // In center mode the counter passes the value going up and coming down, giving two matches.
  assign chan_match = count_tick && (nxt_cnt == chval_ff) && (center_mode || chan_mode != timer_pkg::MODE_CAPTURE);
  assign capture_hit = !center_mode && (chan_mode == timer_pkg::MODE_CAPTURE) && edge_hit(edge_sel, chan_rise, chan_fall);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_ff <= timer_pkg::PRESCALE_RESET;
    end else if (src_tick) begin
      presc_ff <= presc_ff + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= timer_pkg::COUNT_RESET;
      up_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff <= nxt_up;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sc_ff <= timer_pkg::SC_RESET;
      ch_ff <= timer_pkg::CH_RESET;
      mod_ff <= timer_pkg::MODULO_RESET;
    end else if (wr_en) begin
      if (addr == timer_pkg::OFF_STATUS_CONTROL) begin
        sc_ff <= wr_data[5:0];
      end else if (addr == timer_pkg::OFF_CHANNEL_CONTROL) begin
        ch_ff <= wr_data[5:2];
      end else if (addr == timer_pkg::OFF_MODULO_HIGH) begin
        mod_ff[15:8] <= wr_data;
      end else if (addr == timer_pkg::OFF_MODULO_LOW) begin
        mod_ff[7:0] <= wr_data;
      end
    end
  end

  // A capture edge beats a software write of the same cycle, since the event cannot be repeated.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chval_ff <= timer_pkg::VALUE_RESET;
    end else if (capture_hit) begin
      chval_ff <= cnt_ff;
    end else if (wr_en && addr == timer_pkg::OFF_CHANNEL_VALUE_HIGH) begin
      chval_ff[15:8] <= wr_data;
    end else if (wr_en && addr == timer_pkg::OFF_CHANNEL_VALUE_LOW) begin
      chval_ff[7:0] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tof_ff <= 1'b0;
      tof_arm_ff <= 1'b0;
    end else begin
      if (reverse_top || wrap) begin
        tof_ff <= 1'b1;
      end else if (sc_write && !wr_data[timer_pkg::SC_FLAG_BIT] && tof_arm_ff) begin
        tof_ff <= 1'b0;
      end
      if (rd_en && addr == timer_pkg::OFF_STATUS_CONTROL && tof_ff) begin
        tof_arm_ff <= 1'b1;
      end else if (sc_write || !tof_ff) begin
        tof_arm_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chf_ff <= 1'b0;
      chf_arm_ff <= 1'b0;
    end else begin
      if (capture_hit || chan_match) begin
        chf_ff <= 1'b1;
      end else if (ch_write && !wr_data[timer_pkg::CH_FLAG_BIT] && chf_arm_ff) begin
        chf_ff <= 1'b0;
      end
      if (rd_en && addr == timer_pkg::OFF_CHANNEL_CONTROL && chf_ff) begin
        chf_arm_ff <= 1'b1;
      end else if (ch_write || !chf_ff) begin
        chf_arm_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan_out_ff <= 1'b0;
    end else if (center_mode || chan_mode == timer_pkg::MODE_EDGE_PWM || chan_mode == timer_pkg::MODE_EDGE_PWM_ALT) begin
      chan_out_ff <= (nxt_cnt < chval_ff);
    end else if (chan_mode == timer_pkg::MODE_COMPARE) begin
      chan_out_ff <= chan_out_ff ^ chan_match;
    end else begin
      chan_out_ff <= chan_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The first byte read snapshots the live count; the partner byte then comes from the snapshot.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_ff <= timer_pkg::LATCH_IDLE;
      buf_ff <= timer_pkg::COUNT_RESET;
    end else if (sc_write) begin
      latch_ff <= timer_pkg::LATCH_IDLE;
    end else if (rd_en && addr == timer_pkg::OFF_COUNTER_HIGH) begin
      case (latch_ff)
        timer_pkg::LATCH_IDLE: begin
          buf_ff <= cnt_ff;
          latch_ff <= timer_pkg::LATCH_HIGH_READ;
        end
        timer_pkg::LATCH_LOW_READ: latch_ff <= timer_pkg::LATCH_IDLE;
        default: latch_ff <= latch_ff;
      endcase
    end else if (rd_en && addr == timer_pkg::OFF_COUNTER_LOW) begin
      case (latch_ff)
        timer_pkg::LATCH_IDLE: begin
          buf_ff <= cnt_ff;
          latch_ff <= timer_pkg::LATCH_LOW_READ;
        end
        timer_pkg::LATCH_HIGH_READ: latch_ff <= timer_pkg::LATCH_IDLE;
        default: latch_ff <= latch_ff;
      endcase
    end
  end

  always_comb begin
    nxt_rd_data = 8'h00;
    if (addr == timer_pkg::OFF_STATUS_CONTROL) begin
      nxt_rd_data = {tof_ff, 1'b0, sc_ff};
    end else if (addr == timer_pkg::OFF_COUNTER_HIGH) begin
      nxt_rd_data = (latch_ff == timer_pkg::LATCH_IDLE) ? cnt_ff[15:8] : buf_ff[15:8];
    end else if (addr == timer_pkg::OFF_COUNTER_LOW) begin
      nxt_rd_data = (latch_ff == timer_pkg::LATCH_IDLE) ? cnt_ff[7:0] : buf_ff[7:0];
    end else if (addr == timer_pkg::OFF_MODULO_HIGH) begin
      nxt_rd_data = mod_ff[15:8];
    end else if (addr == timer_pkg::OFF_MODULO_LOW) begin
      nxt_rd_data = mod_ff[7:0];
    end else if (addr == timer_pkg::OFF_CHANNEL_CONTROL) begin
      nxt_rd_data = {chf_ff, 1'b0, ch_ff, 2'b00};
    end else if (addr == timer_pkg::OFF_CHANNEL_VALUE_HIGH) begin
      nxt_rd_data = chval_ff[15:8];
    end else begin
      nxt_rd_data = chval_ff[7:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= rd_en ? nxt_rd_data : 8'h00;
    end
  end

  assign rd_data = rd_data_ff;
  assign chan_out = chan_out_ff;
  assign counter_overflow_flag = tof_ff;
  assign channel_flag = chf_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_source_off: assert property (
    (clk_src == timer_pkg::CLK_OFF) |=> (cnt_ff == $past(cnt_ff)) && (presc_ff == $past(presc_ff)))
    else $error("counter moved with clock source off");

  a_bus_rate: assert property (
    (clk_src == timer_pkg::CLK_BUS) && (ps == 3'h0) && !center_mode && (cnt_ff < top)
    |=> (cnt_ff == $past(cnt_ff) + 16'h0001))
    else $error("bus clock with divide by one did not advance counter");

  a_fixed_as_bus: assert property (
    (clk_src == timer_pkg::CLK_FIXED) && !(pll_present && pll_enable) && ($past(presc_ff) != presc_ff)
    |=> (presc_ff == $past(presc_ff) + 7'h01))
    else $error("fixed clock without loop did not run at bus rate");

  a_ext_sync_only: assert property (
    (clk_src == timer_pkg::CLK_EXT) && !ext_rise |=> (presc_ff == $past(presc_ff)))
    else $error("prescaler moved without a synchronised external edge");

  a_prescale_div8: assert property (
    count_tick && (ps == 3'h3) |-> (presc_ff[2:0] == 3'h7))
    else $error("divide by eight ticked at wrong prescaler phase");

  a_read_coherent: assert property (
    rd_en && (addr == timer_pkg::OFF_COUNTER_LOW) && (latch_ff == timer_pkg::LATCH_HIGH_READ)
    |=> (rd_data_ff == $past(buf_ff[7:0])) && (latch_ff == timer_pkg::LATCH_IDLE))
    else $error("low byte did not come from the latched count");

  a_latch_restart: assert property (
    sc_write |=> (latch_ff == timer_pkg::LATCH_IDLE))
    else $error("status write did not restart the read latch");

  a_center_reverse: assert property (
    center_mode && count_tick && up_ff && (cnt_ff >= top) |=> tof_ff && !up_ff)
    else $error("center mode turn at modulo did not set overflow");

  a_capture_flag: assert property (
    capture_hit |=> chf_ff && (chval_ff == $past(cnt_ff)))
    else $error("capture edge did not set flag and store count");

  a_match_flag: assert property (
    chan_match |=> chf_ff ##1 (chf_ff || $past(ch_write)))
    else $error("compare or PWM match did not set channel flag");

  a_clear_needs_read: assert property (
    tof_ff && !tof_arm_ff && sc_write |=> tof_ff)
    else $error("overflow flag cleared without a prior read");

  c_center_turn: cover property (center_mode && reverse_top);
  c_counter_split_read: cover property (
    rd_en && (addr == timer_pkg::OFF_COUNTER_HIGH) ##[1:4] rd_en && (addr == timer_pkg::OFF_COUNTER_LOW));
  c_capture_event: cover property (capture_hit);
  c_flag_cleared: cover property (tof_arm_ff && sc_write && !wr_data[timer_pkg::SC_FLAG_BIT]);

endmodule : timer_pwm_unit
`default_nettype wire

/* src/timer_pkg.sv */
// Package with register map, field positions, reset values and enumerations of the timer unit.
`default_nettype none
package timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFF_COUNTER_HIGH = 3'h1;
  localparam logic [2:0] OFF_COUNTER_LOW = 3'h2;
  localparam logic [2:0] OFF_MODULO_HIGH = 3'h3;
  localparam logic [2:0] OFF_MODULO_LOW = 3'h4;
  localparam logic [2:0] OFF_CHANNEL_CONTROL = 3'h5;
  localparam logic [2:0] OFF_CHANNEL_VALUE_HIGH = 3'h6;
  localparam logic [2:0] OFF_CHANNEL_VALUE_LOW = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_CENTER_BIT = 5;
  localparam int SC_CLKS_LSB = 3;
  localparam int SC_PS_LSB = 0;
  localparam int CH_FLAG_BIT = 7;
  localparam int CH_MODE_LSB = 4;
  localparam int CH_EDGE_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] SC_RESET = 6'h00;
  localparam logic [3:0] CH_RESET = 4'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam logic [15:0] FREE_RUN_TOP = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {CLK_OFF, CLK_BUS, CLK_FIXED, CLK_EXT} clk_src_e;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_EDGE_PWM_ALT} chan_mode_e;
  typedef enum logic [1:0] {LATCH_IDLE, LATCH_HIGH_READ, LATCH_LOW_READ} latch_e;

endpackage : timer_pkg
`default_nettype wire

/* src/pin_sync.sv */
// Three-stage synchroniser that accepts a pin change once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;
  logic fall_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts only when two settled stages agree, so a metastable first stage is never looked at.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= (s2_ff == s3_ff) && s2_ff && !level_ff;
      fall_ff <= (s2_ff == s3_ff) && !s2_ff && level_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s2_ff;
      end
    end
  end

  assign level = level_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule : pin_sync
`default_nettype wire

/* tb/pin_model.sv */
// Far-side model that drives the external clock pin and the channel input pin.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic clk,
  output logic ext_clk_pin,
  output logic chan_pin
);
  initial begin
    ext_clk_pin = 1'b0;
    chan_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // The clock stands low between bursts; each pulse is high four cycles and low five so no edge is lost in the synchroniser.
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : ext_pulses
  // The wait afterwards covers the pin synchroniser delay.
  task automatic chan_level(input logic v);
    @(posedge clk);
    chan_pin <= v;
    repeat (8) @(posedge clk);
  endtask : chan_level
endmodule : pin_model
`default_nettype wire

/* tb/timer_pwm_unit_tb.sv */
// Self-checking bench for the timer unit.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_unit_tb;
  logic clk, resetn, wr_en, rd_en, fixed_clk_tick, pll_present, pll_enable;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data;
  logic [1:0] tick_cnt;
  wire logic ext_clk_pin, chan_pin, chan_out, counter_overflow_flag, channel_flag;
  int miscompares = 0;
  int checks_done = 0;

  timer_pwm_unit DUT (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .ext_clk_pin(ext_clk_pin), .fixed_clk_tick(fixed_clk_tick), .pll_present(pll_present),
    .pll_enable(pll_enable), .chan_pin(chan_pin), .chan_out(chan_out),
    .counter_overflow_flag(counter_overflow_flag), .channel_flag(channel_flag));
  pin_model pins (.clk(clk), .ext_clk_pin(ext_clk_pin), .chan_pin(chan_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The fixed clock source is a pulse every fourth cycle.
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    fixed_clk_tick <= (tick_cnt == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks_done++;
    if (!(got >= lo && got <= hi)) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_in
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // Return after the write has landed, so a check that follows sees the updated state.
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic rd_count(output logic [15:0] c);
    rd(3'h1, c[15:8]);
    rd(3'h2, c[7:0]);
  endtask : rd_count
  task automatic wait_set(input bit chan, input int lim);
    int n;
    n = 0;
    while (n < lim && (chan ? channel_flag : counter_overflow_flag) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    check_eq({15'h0000, chan ? channel_flag : counter_overflow_flag}, 16'h0001);
  endtask : wait_set
  task automatic clear_ch(input logic [7:0] ctl);
    logic [7:0] d;
    rd(3'h5, d);
    wr(3'h5, ctl);
  endtask : clear_ch
  // Counts counter advances over a span; bus and fixed spans are cycles, external spans are pin pulses.
  task automatic run_src(input logic [7:0] sc, input int m, input bit ext, input logic [15:0] lo,
      input logic [15:0] hi);
    logic [15:0] a, b;
    rd_count(a);
    wr(3'h0, sc);
    if (ext) pins.ext_pulses(m);
    else repeat (m) @(posedge clk);
    wr(3'h0, 8'h00);
    rd_count(b);
    check_in(b - a, lo, hi);
  endtask : run_src
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      check_eq({8'h00, d}, 16'h0000);
    end
  endtask : t_reset
  task automatic t_sources;
    logic [15:0] a, b;
    rd_count(a);
    repeat (20) @(posedge clk);
    wr(3'h1, 8'h55);
    wr(3'h2, 8'haa);
    rd_count(b);
    check_eq(b, a);
    for (int k = 0; k < 8; k++) begin
      run_src(8'h08 | 8'(k), 256, 1'b0, 16'((256 >> k) - 1), 16'((256 >> k) + 2));
    end
    pll_present <= 1'b1;
    pll_enable <= 1'b1;
    run_src(8'h10, 64, 1'b0, 16'h000f, 16'h0012);
    pll_enable <= 1'b0;
    run_src(8'h10, 64, 1'b0, 16'h003f, 16'h0042);
    pll_present <= 1'b0;
    pll_enable <= 1'b1;
    run_src(8'h10, 64, 1'b0, 16'h003f, 16'h0042);
    run_src(8'h18, 12, 1'b1, 16'h000c, 16'h000c);
    run_src(8'h19, 16, 1'b1, 16'h0007, 16'h0009);
  endtask : t_sources
  task automatic t_latch;
    logic [7:0] l1, l2, h;
    wr(3'h0, 8'h08);
    rd(3'h2, l1);
    repeat (10) @(posedge clk);
    rd(3'h2, l2);
    check_eq({8'h00, l2}, {8'h00, l1});
    rd(3'h1, h);
    rd(3'h2, l2);
    check_in({8'h00, 8'(l2 - l1)}, 16'h000a, 16'h0028);
    rd(3'h2, l1);
    wr(3'h0, 8'h08);
    rd(3'h2, l2);
    check_in({8'h00, 8'(l2 - l1)}, 16'h0002, 16'h0014);
  endtask : t_latch
  task automatic t_capture;
    logic [7:0] ctl;
    for (int e = 0; e < 4; e++) begin
      ctl = {4'h0, 2'(e), 2'b00};
      wr(3'h5, ctl);
      clear_ch(ctl);
      pins.chan_level(1'b1);
      check_eq({15'h0000, channel_flag}, {15'h0000, e[0]});
      check_eq({15'h0000, chan_out}, 16'h0001);
      clear_ch(ctl);
      pins.chan_level(1'b0);
      check_eq({15'h0000, channel_flag}, {15'h0000, e[1]});
      check_eq({15'h0000, chan_out}, 16'h0000);
    end
  endtask : t_capture
  task automatic t_compare;
    logic [7:0] modes [2] = '{8'h10, 8'h20};
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h40);
    wr(3'h6, 8'h00);
    wr(3'h7, 8'h20);
    for (int i = 0; i < 2; i++) begin
      wr(3'h5, modes[i]);
      clear_ch(modes[i]);
      wait_set(1'b1, 80);
      clear_ch(modes[i]);
      check_eq({15'h0000, channel_flag}, 16'h0000);
      wait_set(1'b1, 80);
    end
  endtask : t_compare
  task automatic t_center;
    logic [7:0] d;
    // Stop the counter first so no wrap can land on the clearing write.
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h7, 8'h08);
    rd(3'h0, d);
    wr(3'h0, 8'h00);
    check_eq({15'h0000, counter_overflow_flag}, 16'h0000);
    wr(3'h0, 8'h28);
    wait_set(1'b0, 60);
    wr(3'h0, 8'h28);
    check_eq({15'h0000, counter_overflow_flag}, 16'h0001);
    rd(3'h0, d);
    check_eq({8'h00, d & 8'h80}, 16'h0080);
    wr(3'h0, 8'h28);
    check_eq({15'h0000, counter_overflow_flag}, 16'h0000);
    clear_ch(8'h20);
    check_eq({15'h0000, channel_flag}, 16'h0000);
    wait_set(1'b1, 40);
    clear_ch(8'h20);
    wait_set(1'b1, 24);
  endtask : t_center
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    tick_cnt = 2'h0;
    fixed_clk_tick = 1'b0;
    pll_present = 1'b0;
    pll_enable = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_sources();
    t_latch();
    t_capture();
    t_compare();
    t_center();
    close_out();
  end
  // A healthy run takes some three thousand cycles.
  initial begin
    #5000000;
    miscompares++;
    close_out();
  end
endmodule : timer_pwm_unit_tb
`default_nettype wire
